// ---- shared/pwm_ctrl_pkg.sv ----
package pwm_ctrl_pkg;
    localparam int NUM_GEN = 3;
    localparam logic [3:0] ADDR_TBCON = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_TB_STATUS = 4'h5;
    localparam logic [3:0] ADDR_GEN_CTRL = 4'h8;
    localparam logic [3:0] ADDR_GEN_PERIOD = 4'hC;
    localparam int TB_ON = 15;
    localparam int TB_HALT_IDLE = 13;
    localparam int TB_SE_PEND = 12;
    localparam int TB_SE_IRQ = 11;
    localparam int TB_IMM_PER = 10;
    localparam int TB_SYNC_POL = 9;
    localparam int TB_SYNC_OUT = 8;
    localparam int TB_EXT_SYNC = 7;
    localparam int TB_SRC_LO = 4;
    localparam int TB_PS_LO = 0;
    localparam logic [15:0] TB_WMASK = 16'hAFFF;
    localparam int GC_FLT_PEND = 15;
    localparam int GC_CL_PEND = 14;
    localparam int GC_TRG_PEND = 13;
    localparam int GC_FLT_IRQ = 12;
    localparam int GC_CL_IRQ = 11;
    localparam int GC_TRG_IRQ = 10;
    localparam int GC_OWN_PER = 9;
    localparam int GC_DT_LO = 6;
    localparam int GC_DT_COMP = 5;
    localparam int GC_CAM = 2;
    localparam logic [15:0] GC_WMASK = 16'h1FE7;
    localparam logic [1:0] DT_COMP_MODE = 2'h3;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
endpackage

// ---- rtl/pwm_gen_flags.sv ----
`timescale 1ns/1ps
module pwm_gen_flags (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic fault_evt,
    input wire logic current_limit_evt,
    input wire logic trigger_evt,
    input wire logic [15:0] shared_period,
    input wire logic [15:0] own_period,
    output logic [15:0] ctrl_q,
    output logic [15:0] eff_period_q,
    output logic centre_mode_q,
    output logic dt_comp_active_q,
    output logic irq
);
    logic [15:0] cfg_q;
    logic flt_q, cl_q, trg_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= pwm_ctrl_pkg::RESET_VAL;
        end else if (wr_en) begin
            cfg_q <= wr_data & pwm_ctrl_pkg::GC_WMASK;
        end
    end

    // Set wins over clear; a cleared enable also clears the flag
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_q <= 1'b0;
        end else if (fault_evt && cfg_q[pwm_ctrl_pkg::GC_FLT_IRQ]) begin
            flt_q <= 1'b1; // [R11]
        end else if (!cfg_q[pwm_ctrl_pkg::GC_FLT_IRQ]) begin
            flt_q <= 1'b0; // [R11]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cl_q <= 1'b0;
        end else if (current_limit_evt && cfg_q[pwm_ctrl_pkg::GC_CL_IRQ]) begin
            cl_q <= 1'b1; // [R12]
        end else if (!cfg_q[pwm_ctrl_pkg::GC_CL_IRQ]) begin
            cl_q <= 1'b0; // [R12]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trg_q <= 1'b0;
        end else if (trigger_evt && cfg_q[pwm_ctrl_pkg::GC_TRG_IRQ]) begin
            trg_q <= 1'b1; // [R15]
        end else if (!cfg_q[pwm_ctrl_pkg::GC_TRG_IRQ]) begin
            trg_q <= 1'b0; // [R15]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eff_period_q <= pwm_ctrl_pkg::PERIOD_RESET;
            centre_mode_q <= 1'b0;
            dt_comp_active_q <= 1'b0;
        end else begin
            eff_period_q <= cfg_q[pwm_ctrl_pkg::GC_OWN_PER] ? own_period
                                                             : shared_period; // [R16]
            centre_mode_q <= cfg_q[pwm_ctrl_pkg::GC_CAM]
                             && cfg_q[pwm_ctrl_pkg::GC_OWN_PER]; // [R13]
            dt_comp_active_q <= cfg_q[pwm_ctrl_pkg::GC_DT_COMP]
                && (cfg_q[pwm_ctrl_pkg::GC_DT_LO +: 2] == pwm_ctrl_pkg::DT_COMP_MODE); // [R14]
        end
    end

    assign ctrl_q = {flt_q, cl_q, trg_q, cfg_q[12:0]};
    assign irq = flt_q | cl_q | trg_q;
endmodule

// ---- rtl/pwm_time_base_generator_control.sv ----
`timescale 1ns/1ps
// Function
// [R01] Whole module runs only while module_on is one; gen_period, gen_centre_mode and gen_dt_comp_active still update while off.
// [R02] halt_in_idle stops the primary time base while the CPU idles.
// [R03] special_event_pending set and cleared by hardware, not writable.
// [R04] Special event interrupt forwarded only when special_event_irq_on is one; irq still gets it through summary status bit 0 regardless.
// [R05] immediate_period_load loads period at once, else at cycle boundary.
// [R06] sync_polarity_invert makes sync input and output active-low.
// [R07] Sync output pin driven only when sync_out_on is one.
// [R08] ext_sync_on lets selected external sync restart the time base.
// [R09] Software changes sync and update settings only while module is off.
// [R10] Software sets period slightly above the external sync period.
// [R11] Fault flag set by hardware; clearing its enable clears it.
// [R12] Current-limit flag set by hardware; clearing its enable clears it.
// [R13] Centre-aligned mode applies only with an independent period.
// [R14] Dead-time compensation polarity honoured only when dead-time field is 11.
// [R15] Trigger flag set on trigger while enabled; clearing enable clears it.
// [R16] Independent period bit picks own period, else shared primary period.
module pwm_time_base_generator_control (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_idle,
    input wire logic [7:0] sync_input_pin,
    output logic sync_output_pin,
    output logic sync_output_pin_oe_n,
    input wire logic [2:0] fault_in,
    input wire logic [2:0] current_limit_in,
    input wire logic [2:0] trigger_in,
    output logic [15:0] time_base_count,
    output logic [47:0] gen_period,
    output logic [2:0] gen_centre_mode,
    output logic [2:0] gen_dt_comp_active,
    output logic special_event_irq,
    output logic irq
);
    localparam int NG = pwm_ctrl_pkg::NUM_GEN;

    logic rst_s1_q, rst_n;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    logic [15:0] tbcon_q, period_buf_q, period_act_q, count_q;
    logic [15:0] gper_q [NG];
    logic [15:0] gen_ctrl [NG];
    logic [15:0] gen_eff [NG];
    logic [2:0] gen_irq;
    logic [3:0] ps_cnt_q;
    logic se_pend_q;
    logic [2:0] irq_stat_q, irq_en_q;
    logic ack_q;
    logic sync_in_q, sync_prev_q;

    // One wait cycle so read data come from a register; writes land on the completing edge
    wire acc = (avs_read | avs_write) & ~ack_q;
    wire wr = avs_write & ack_q & (&avs_byteenable[1:0]);
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    wire mod_on = tbcon_q[pwm_ctrl_pkg::TB_ON];
    wire run = mod_on && !(tbcon_q[pwm_ctrl_pkg::TB_HALT_IDLE] && cpu_idle); // [R01] [R02]
    wire pol = tbcon_q[pwm_ctrl_pkg::TB_SYNC_POL];
    wire [2:0] src = tbcon_q[pwm_ctrl_pkg::TB_SRC_LO +: 3];
    wire [3:0] ps_lim = tbcon_q[pwm_ctrl_pkg::TB_PS_LO +: 4];
    wire sync_lvl = sync_input_pin[src] ^ pol; // [R06]
    wire ext_rst = tbcon_q[pwm_ctrl_pkg::TB_EXT_SYNC] && sync_in_q && !sync_prev_q; // [R08]
    wire wrap = run && (count_q >= period_act_q);
    wire restart = wrap || (mod_on && ext_rst);

    // Settings written while running are taken anyway; software keeps that order
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tbcon_q <= pwm_ctrl_pkg::RESET_VAL;
        end else if (wr && avs_address == pwm_ctrl_pkg::ADDR_TBCON) begin
            tbcon_q <= avs_writedata[15:0] & pwm_ctrl_pkg::TB_WMASK; // [R09]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_in_q <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_in_q <= sync_lvl;
            sync_prev_q <= sync_in_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_buf_q <= pwm_ctrl_pkg::PERIOD_RESET;
        end else if (wr && avs_address == pwm_ctrl_pkg::ADDR_PERIOD) begin
            period_buf_q <= avs_writedata[15:0]; // [R10]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_act_q <= pwm_ctrl_pkg::PERIOD_RESET;
        end else if (tbcon_q[pwm_ctrl_pkg::TB_IMM_PER] || restart || !mod_on) begin
            period_act_q <= period_buf_q; // [R05]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
        end else if (!mod_on) begin
            count_q <= 16'h0000; // [R01]
        end else if (restart) begin
            count_q <= 16'h0000; // [R08]
        end else if (run) begin
            count_q <= count_q + 16'h0001; // [R02]
        end
    end

    // Special event: postscaled wraps of the time base
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_cnt_q <= 4'h0;
            se_pend_q <= 1'b0;
        end else begin
            if (!mod_on) begin
                ps_cnt_q <= 4'h0;
            end else if (wrap) begin
                ps_cnt_q <= (ps_cnt_q >= ps_lim) ? 4'h0 : ps_cnt_q + 4'h1;
            end
            se_pend_q <= wrap && (ps_cnt_q >= ps_lim); // [R03]
        end
    end

    assign special_event_irq = se_pend_q && tbcon_q[pwm_ctrl_pkg::TB_SE_IRQ]; // [R04]

    // Sync output pulses on each restart, shaped by the polarity bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_output_pin <= 1'b0;
            sync_output_pin_oe_n <= 1'b1;
        end else begin
            sync_output_pin <= restart ^ pol; // [R06]
            sync_output_pin_oe_n <= !(tbcon_q[pwm_ctrl_pkg::TB_SYNC_OUT] && mod_on); // [R07]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            time_base_count <= 16'h0000;
        end else begin
            time_base_count <= count_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NG; g++) begin : gen_g
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    gper_q[g] <= pwm_ctrl_pkg::PERIOD_RESET;
                end else if (wr && avs_address
                             == pwm_ctrl_pkg::ADDR_GEN_PERIOD + 4'(g)) begin
                    gper_q[g] <= avs_writedata[15:0];
                end
            end
            pwm_gen_flags u_flags (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .wr_en(wr && avs_address == pwm_ctrl_pkg::ADDR_GEN_CTRL + 4'(g)),
                .wr_data(avs_writedata[15:0]),
                .fault_evt(fault_in[g] && mod_on),
                .current_limit_evt(current_limit_in[g] && mod_on),
                .trigger_evt(trigger_in[g] && mod_on),
                .shared_period(period_act_q),
                .own_period(gper_q[g]),
                .ctrl_q(gen_ctrl[g]),
                .eff_period_q(gen_eff[g]),
                .centre_mode_q(gen_centre_mode[g]),
                .dt_comp_active_q(gen_dt_comp_active[g]),
                .irq(gen_irq[g])
            );
            assign gen_period[16*g +: 16] = gen_eff[g];
        end
    endgenerate

    // Summary status: 0 special event, 1 any generator flag, 2 external sync restart (needs ext_sync_on and module on)
    wire [2:0] evt = {ext_rst && mod_on, |gen_irq, se_pend_q};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= evt | (irq_stat_q & ~((wr && avs_address
                == pwm_ctrl_pkg::ADDR_IRQ_CLEAR) ? avs_writedata[2:0] : 3'h0));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= 3'h0;
        end else if (wr && avs_address == pwm_ctrl_pkg::ADDR_IRQ_ENABLE) begin
            irq_en_q <= avs_writedata[2:0];
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    logic [15:0] rd_d;
    always_comb begin
        rd_d = 16'h0000;
        unique case (avs_address)
            pwm_ctrl_pkg::ADDR_TBCON: rd_d = tbcon_q | (16'(se_pend_q) << pwm_ctrl_pkg::TB_SE_PEND);
            pwm_ctrl_pkg::ADDR_PERIOD: rd_d = period_buf_q;
            pwm_ctrl_pkg::ADDR_IRQ_STATUS: rd_d = {13'h0000, irq_stat_q};
            pwm_ctrl_pkg::ADDR_IRQ_ENABLE: rd_d = {13'h0000, irq_en_q};
            pwm_ctrl_pkg::ADDR_TB_STATUS: rd_d = count_q;
            4'h8, 4'h9, 4'hA: rd_d = gen_ctrl[avs_address[1:0]];
            4'hC, 4'hD, 4'hE: rd_d = gper_q[avs_address[1:0]];
            default: rd_d = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (acc && avs_read) begin
            avs_readdata <= {16'h0000, rd_d};
        end
    end
endmodule

// ---- tb/pwm_ctrl_checker.sv ----
`timescale 1ns/1ps
module pwm_ctrl_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic sync_output_pin_oe_n,
    input wire logic [15:0] time_base_count,
    input wire logic [2:0] gen_centre_mode,
    input wire logic [2:0] gen_dt_comp_active,
    input wire logic special_event_irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    logic [15:0] d;
    assign d = avs_writedata[15:0];
    // Partial lane writes are dropped, so they start nothing
    sequence s_wr(a);
        avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[1:0] == 2'h3;
    endsequence
    sequence s_tb;
        s_wr(pwm_ctrl_pkg::ADDR_TBCON);
    endsequence
    property p_step;
        !$stable(time_base_count) |->
            time_base_count == $past(time_base_count) + 16'h0001 || time_base_count == 16'h0000;
    endproperty
    property p_on;
        s_tb ##0 (d[15] && !d[13]) |-> ##4 !$stable(time_base_count);
    endproperty
    property p_off;
        s_tb ##0 !d[15] |-> ##4 $stable(time_base_count);
    endproperty
    property p_oe_on;
        s_tb ##0 (d[15] && d[8]) |-> ##2 !sync_output_pin_oe_n;
    endproperty
    property p_oe_off;
        s_tb ##0 !(d[15] && d[8]) |-> ##2 sync_output_pin_oe_n;
    endproperty
    property p_se;
        s_tb ##0 !d[11] |-> ##2 !special_event_irq [*2];
    endproperty
    property p_cam;
        s_wr(pwm_ctrl_pkg::ADDR_GEN_CTRL) |->
            ##2 gen_centre_mode[0] == ($past(d[2], 2) && $past(d[9], 2));
    endproperty
    property p_dt;
        s_wr(pwm_ctrl_pkg::ADDR_GEN_CTRL) |-> ##2 gen_dt_comp_active[0] ==
            ($past(d[7], 2) && $past(d[6], 2) && $past(d[5], 2));
    endproperty
    a_step: assert property (p_step) else $error("time base jumped");
    a_on: assert property (p_on) else $error("time base idle while on");
    a_off: assert property (p_off) else $error("time base runs while off");
    a_oe_on: assert property (p_oe_on) else $error("sync out not driven");
    a_oe_off: assert property (p_oe_off) else $error("sync out driven");
    a_se: assert property (p_se) else $error("special event irq while off");
    a_cam: assert property (p_cam) else $error("centre mode wrong");
    a_dt: assert property (p_dt) else $error("dead time comp wrong");
endmodule

bind pwm_time_base_generator_control pwm_ctrl_checker u_chk (.core_clk, .nrst, .avs_address,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .sync_output_pin_oe_n,
    .time_base_count, .gen_centre_mode, .gen_dt_comp_active, .special_event_irq);

// ---- tb/far_side_model.sv ----
`timescale 1ns/1ps
// Sync sources idle at their inactive level; events are one-cycle levels
module far_side_model (
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [3:0] sel,
    input wire logic pol,
    output logic [7:0] sync_input_pin,
    output logic [2:0] fault_in,
    output logic [2:0] current_limit_in,
    output logic [2:0] trigger_in
);
    logic on_q = 1'b0;
    logic [3:0] sel_q = 4'h0;
    always @(posedge core_clk) begin
        on_q <= fire;
        sel_q <= sel;
    end
    assign sync_input_pin = {8{pol}} ^ (on_q && !sel_q[3] ? 8'h01 << sel_q[2:0] : 8'h00);
    assign fault_in = {3{on_q && sel_q == 4'h8}};
    assign current_limit_in = {3{on_q && sel_q == 4'h9}};
    assign trigger_in = {3{on_q && sel_q == 4'hA}};
endmodule

// ---- tb/pwm_time_base_generator_control_tb.sv ----
`timescale 1ns/1ps
module pwm_time_base_generator_control_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpu_idle = 1'b0;
    logic [7:0] sync_input_pin;
    logic sync_output_pin;
    logic sync_output_pin_oe_n;
    logic [2:0] fault_in;
    logic [2:0] current_limit_in;
    logic [2:0] trigger_in;
    logic [15:0] time_base_count;
    logic [47:0] gen_period;
    logic [2:0] gen_centre_mode;
    logic [2:0] gen_dt_comp_active;
    logic special_event_irq;
    logic irq;
    logic fire = 1'b0;
    logic [3:0] sel = 4'h0;
    logic pol = 1'b0;
    logic [31:0] q;
    logic [15:0] cur = 16'h0000;
    logic [3:0] ga;
    int errors = 0;
    int n_compared = 0;
    int n0;
    int n1;
    pwm_time_base_generator_control u_dut (.core_clk, .nrst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .cpu_idle, .sync_input_pin, .sync_output_pin, .sync_output_pin_oe_n, .fault_in,
        .current_limit_in, .trigger_in, .time_base_count, .gen_period, .gen_centre_mode,
        .gen_dt_comp_active, .special_event_irq, .irq);
    far_side_model u_far (.core_clk, .fire, .sel, .pol, .sync_input_pin, .fault_in,
        .current_limit_in, .trigger_in);
    initial forever #4 core_clk = ~core_clk;
    task results;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmp(input logic [47:0] g, input logic [47:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task bus(input logic rw, input logic [3:0] a, input logic [15:0] d);
        int i;
        i = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_read <= rw;
        avs_write <= !rw;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && i < 50) begin
            @(posedge core_clk);
            i++;
        end
        if (i == 50) begin
            errors++;
            results();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b0, a, d);
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        bus(1'b1, a, 16'h0000);
        cmp({16'h0000, q}, {32'h00000000, e});
    endtask
    task cfg(input logic [15:0] d);
        wr(pwm_ctrl_pkg::ADDR_TBCON, cur & 16'h7FFF);
        wr(pwm_ctrl_pkg::ADDR_TBCON, d & 16'h7FFF);
        wr(pwm_ctrl_pkg::ADDR_TBCON, d);
        cur = d;
    endtask
    task pulse(input logic [3:0] s);
        @(posedge core_clk);
        sel <= s;
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(pwm_ctrl_pkg::ADDR_TBCON, pwm_ctrl_pkg::RESET_VAL);
        rd(pwm_ctrl_pkg::ADDR_PERIOD, pwm_ctrl_pkg::PERIOD_RESET);
        cmp(gen_period, {3{pwm_ctrl_pkg::PERIOD_RESET}});
        cmp(48'(sync_output_pin_oe_n), 48'h1);
        wr(pwm_ctrl_pkg::ADDR_TBCON, 16'h1000);
        rd(pwm_ctrl_pkg::ADDR_TBCON, 16'h0000);
        rd(4'h6, 16'h0000);
        wr(pwm_ctrl_pkg::ADDR_PERIOD, 16'h0004);
        for (int i = 0; i < 2; i++) begin
            pol <= i[0];
            cfg(16'h8100 | 16'(i) << 11 | 16'(i) << 9);
            n0 = 0;
            n1 = 0;
            // Window of four full periods once the count has left reset
            @(negedge core_clk);
            repeat (20) begin
                @(negedge core_clk);
                n0 += special_event_irq;
                n1 += sync_output_pin ^ pol;
            end
            cmp(48'(n0), 48'(4 * i));
            cmp(48'(n1), 48'h4);
            cmp(48'(sync_output_pin_oe_n), 48'h0);
        end
        cfg(16'h8000);
        wr(pwm_ctrl_pkg::ADDR_IRQ_ENABLE, 16'h0001);
        repeat (2) @(negedge core_clk);
        cmp(48'(sync_output_pin_oe_n), 48'h1);
        cmp(48'(irq), 48'h1);
        wr(pwm_ctrl_pkg::ADDR_IRQ_ENABLE, 16'h0000);
        @(negedge core_clk);
        cmp(48'(irq), 48'h0);
        cfg(16'h0000);
        wr(pwm_ctrl_pkg::ADDR_IRQ_CLEAR, 16'h0007);
        bus(1'b1, pwm_ctrl_pkg::ADDR_IRQ_STATUS, 16'h0000);
        cmp(48'(q[0]), 48'h0);
        wr(pwm_ctrl_pkg::ADDR_PERIOD, 16'h00FF);
        for (int h = 0; h < 2; h++) begin
            cfg(16'h8000 | 16'(h) << 13);
            cpu_idle <= 1'b1;
            repeat (3) @(negedge core_clk);
            q = {16'h0000, time_base_count};
            repeat (3) @(negedge core_clk);
            cmp(48'(q[15:0] === time_base_count), 48'(h));
            @(posedge core_clk);
            cpu_idle <= 1'b0;
        end
        pol <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            cfg(16'h8220 | 16'(e) << 7);
            repeat (60) @(posedge core_clk);
            pulse(4'h2);
            @(negedge core_clk);
            cmp(48'(time_base_count < 16'h0008), 48'(e));
            bus(1'b1, pwm_ctrl_pkg::ADDR_IRQ_STATUS, 16'h0000);
            cmp(48'(q[2]), 48'(e));
        end
        wr(pwm_ctrl_pkg::ADDR_IRQ_ENABLE, 16'h0002);
        for (int k = 0; k < 3; k++) begin
            ga = pwm_ctrl_pkg::ADDR_GEN_CTRL + 4'(k);
            pulse(4'h8 + 4'(k));
            rd(ga, 16'h0000);
            wr(ga, 16'h1000 >> k);
            pulse(4'h8 + 4'(k));
            rd(ga, 16'h9000 >> k);
            @(negedge core_clk);
            cmp(48'(irq), 48'h1);
            wr(ga, 16'h0000);
            rd(ga, 16'h0000);
            wr(pwm_ctrl_pkg::ADDR_IRQ_CLEAR, 16'h0002);
            @(negedge core_clk);
            cmp(48'(irq), 48'h0);
        end
        cfg(16'h8400);
        wr(pwm_ctrl_pkg::ADDR_PERIOD, 16'h0040);
        wr(pwm_ctrl_pkg::ADDR_GEN_PERIOD, 16'h0123);
        for (int j = 0; j < 2; j++) begin
            wr(pwm_ctrl_pkg::ADDR_GEN_CTRL, j ? 16'h02E4 : 16'h00A4);
            repeat (70) @(negedge core_clk);
            cmp(48'(gen_centre_mode[0]), 48'(j));
            cmp(48'(gen_dt_comp_active[0]), 48'(j));
            cmp(48'(gen_period[15:0]), j ? 48'h0123 : 48'h0040);
        end
        results();
    end
endmodule
